// ==== logic/sisc_defines.vh ====
// register map, field layout, reset values and widths of the status capture block
`ifndef SISC_DEFINES_VH
`define SISC_DEFINES_VH

// ----
// register indices (byte address is four times the index)
// ----
`define SISC_IDX_STAT1      6'h07
`define SISC_IDX_STAT2      6'h08
`define SISC_IDX_MASK1      6'h09
`define SISC_IDX_MODE1_MSB  6'h0A
`define SISC_IDX_MODE1_LSB  6'h0B
`define SISC_IDX_MASK2      6'h0C
`define SISC_IDX_MODE2_MSB  6'h0D
`define SISC_IDX_MODE2_LSB  6'h0E
`define SISC_IDX_RXERR      6'h11

// ----
// field positions
// ----
`define SISC_S1_RIGHT_OVR   3
`define SISC_S1_CBUF_DE     2
`define SISC_S1_CBUF_EF     1
`define SISC_S1_RX_ERR      0
`define SISC_S2_CONV_OVF    5
`define SISC_S2_CONV_RELOCK 4
`define SISC_S2_UBUF_DE     3
`define SISC_S2_UBUF_EF     2
`define SISC_S2_SUBCODE     1
`define SISC_S2_UFIFO_OVW   0

// ----
// trigger codes, reset values, widths
// ----
`define SISC_TRIG_RISE      2'h0
`define SISC_TRIG_FALL      2'h1
`define SISC_TRIG_LEVEL     2'h2
`define SISC_REG_RESET      8'h00
`define SISC_NFLAG          10
`define SISC_SAMPLE_W       24
`define SISC_ACC_W          26
`define SISC_RESP_OKAY      2'h0
`define SISC_RESP_SLVERR    2'h2

`endif

// ==== logic/sisc_flag_cell.v ====
// one sticky interrupt status flag with trigger mode and mask
module sisc_flag_cell (
    // clock and reset
    input  wire       i_clk,
    input  wire       i_rst_b,
    // control
    input  wire       i_src,
    input  wire [1:0] i_mode,
    input  wire       i_mask,
    input  wire       i_rd_clr,
    // status
    output reg        o_flag
);
`include "sisc_defines.vh"

    reg  src_prev;  // source one cycle ago, for edge modes
    reg  hit;       // trigger seen this cycle

    // ----------
    // trigger detect
    // ----------
    always @* begin
        case (i_mode)
            `SISC_TRIG_RISE:  hit = i_src & ~src_prev;
            `SISC_TRIG_FALL:  hit = ~i_src & src_prev;
            `SISC_TRIG_LEVEL: hit = i_src;
            default:          hit = 1'b0;  // reserved code never fires
        endcase
    end

    // ----------
    // sticky flag: set wins over the read clear
    // ----------
    always @(posedge i_clk or negedge i_rst_b) begin
        if (!i_rst_b) begin
            src_prev <= 1'b0;
            o_flag   <= 1'b0;
        end else begin
            src_prev <= i_src;
            if (!i_mask)
                o_flag <= 1'b0;  // masked flag always reads zero
            else if (hit)
                o_flag <= 1'b1;  // level mode refires, so it survives a read
            else if (i_rd_clr)
                o_flag <= 1'b0;
        end
    end

endmodule // sisc_flag_cell

// ==== logic/sisc_sat.v ====
// saturating narrowing of the right-channel converter result
`include "sisc_defines.vh"

module sisc_sat (
    // wide converter result
    input  wire [`SISC_ACC_W-1:0]    i_acc,
    // clipped result
    output wire [`SISC_SAMPLE_W-1:0] o_sample,
    output wire                      o_over
);

    wire [`SISC_ACC_W-`SISC_SAMPLE_W:0] top;  // sign plus headroom bits

    assign top = i_acc[`SISC_ACC_W-1:`SISC_SAMPLE_W-1];

    // any headroom bit unlike the sign means out of range
    assign o_over = ~((&top) | ~(|top));

    // clip to full scale of the right polarity instead of wrapping
    assign o_sample = !o_over ? i_acc[`SISC_SAMPLE_W-1:0] :
                      i_acc[`SISC_ACC_W-1] ? {1'b1, {(`SISC_SAMPLE_W-1){1'b0}}} :
                      {1'b0, {(`SISC_SAMPLE_W-1){1'b1}}};

endmodule // sisc_sat

// ==== logic/sisc_top.v ====
// interrupt status capture with an AXI4-Lite register slave
//
// How it works
// - right over-range flag from converter range check
// - over-range output clips to full scale
// - C-buffer D to E busy drives flag
// - C-buffer E to F busy drives flag
// - second status register read-only, bits 7:6 zero
// - flag set if condition occurred since read
// - read clears; level mode with source stays
// - masked status bit always reads zero
// - status registers reset to zero
// - mask gates status and pin; resets zero
// - two-bit trigger: rise, fall, level, reserved
`include "sisc_defines.vh"

module sisc_top (
    // clock and reset
    input  wire        i_clk,
    input  wire        i_rst_b,

    // axi4-lite write address
    input  wire        i_awvalid,
    output reg         o_awready,
    input  wire [7:0]  i_awaddr,

    // axi4-lite write data
    input  wire        i_wvalid,
    output reg         o_wready,
    input  wire [31:0] i_wdata,
    input  wire [3:0]  i_wstrb,

    // axi4-lite write response
    output reg         o_bvalid,
    input  wire        i_bready,
    output reg  [1:0]  o_bresp,

    // axi4-lite read address
    input  wire        i_arvalid,
    output reg         o_arready,
    input  wire [7:0]  i_araddr,

    // axi4-lite read data
    output reg         o_rvalid,
    input  wire        i_rready,
    output reg  [31:0] o_rdata,
    output reg  [1:0]  o_rresp,

    // event sources
    input  wire [25:0] i_right_acc,
    input  wire        i_right_vld,
    input  wire        i_cbuf_de_busy,
    input  wire        i_cbuf_ef_busy,
    input  wire        i_rx_err,
    input  wire [7:0]  i_rx_err_cause,
    input  wire        i_conv_overflow,
    input  wire        i_conv_tracking,
    input  wire        i_ubuf_de_busy,
    input  wire        i_ubuf_ef_busy,
    input  wire        i_subcode_ready,
    input  wire        i_ufifo_overwrite,

    // outputs
    output reg  [23:0] o_right_sample,
    output reg         o_int
);

    // -----------------------------------------------------------------
    // software registers
    // -----------------------------------------------------------------
    reg  [7:0]  mask1;      // status 1 enables
    reg  [7:0]  mode1_msb;  // status 1 trigger code, high bit
    reg  [7:0]  mode1_lsb;  // status 1 trigger code, low bit
    reg  [7:0]  mask2;      // status 2 enables, bits 7:6 unused
    reg  [7:0]  mode2_msb;  // status 2 trigger code, high bit
    reg  [7:0]  mode2_lsb;  // status 2 trigger code, low bit

    // -----------------------------------------------------------------
    // write channel state
    // -----------------------------------------------------------------
    reg         aw_full;    // write address held
    reg         w_full;     // write data held
    reg  [5:0]  wr_idx;     // held word index
    reg  [7:0]  wr_byte;    // held low data byte
    reg         wr_en0;     // held strobe of byte lane 0
    wire        aw_take;    // address handshake this edge
    wire        w_take;     // data handshake this edge
    wire        wr_do;      // perform the held write
    wire        next_aw_full;
    wire        next_w_full;
    wire        next_bvalid;
    // all next_ terms are combinational
    reg         wr_hit;     // held index is mapped

    // -----------------------------------------------------------------
    // read channel state
    // -----------------------------------------------------------------
    wire        ar_take;    // read address handshake this edge
    wire        next_rvalid;
    wire [5:0]  rd_idx;     // requested word index
    reg  [7:0]  rd_val;     // mapped read value
    reg         rd_hit;     // requested index is mapped

    // -----------------------------------------------------------------
    // flag wiring
    // -----------------------------------------------------------------
    wire [`SISC_NFLAG-1:0] src;     // condition per flag
    wire [`SISC_NFLAG-1:0] f_mask;  // enable per flag
    wire [`SISC_NFLAG-1:0] f_msb;   // trigger code high bit per flag
    wire [`SISC_NFLAG-1:0] f_lsb;   // trigger code low bit per flag
    wire [`SISC_NFLAG-1:0] f_clr;   // read clear per flag
    wire [`SISC_NFLAG-1:0] flag;    // sticky status per flag
    wire [7:0]  stat1;              // first status register view
    wire [7:0]  stat2;              // second status register view
    wire        clr1;               // read of status 1 taken
    wire        clr2;               // read of status 2 taken
    wire [`SISC_SAMPLE_W-1:0] sat_sample;
    wire        sat_over;           // right result beyond range

    // -----------------------------------------------------------------
    // right channel range check and clip
    // -----------------------------------------------------------------
    sisc_sat u_sat (
        .i_acc    (i_right_acc),
        .o_sample (sat_sample),
        .o_over   (sat_over)
    );

    // clipped sample held for the output port
    always @(posedge i_clk or negedge i_rst_b) begin
        if (!i_rst_b)
            o_right_sample <= {`SISC_SAMPLE_W{1'b0}};
        else if (i_right_vld)
            o_right_sample <= sat_sample;
    end

    // ----------
    // flag sources, low four from status 1, upper six from status 2
    // ----------
    assign src[`SISC_S1_RIGHT_OVR] = i_right_vld & sat_over;
    assign src[`SISC_S1_CBUF_DE]   = i_cbuf_de_busy;
    assign src[`SISC_S1_CBUF_EF]   = i_cbuf_ef_busy;
    assign src[`SISC_S1_RX_ERR]    = i_rx_err;

    // status 2 sources
    assign src[4+`SISC_S2_CONV_OVF]    = i_conv_overflow;
    assign src[4+`SISC_S2_CONV_RELOCK] = i_conv_tracking;
    assign src[4+`SISC_S2_UBUF_DE]     = i_ubuf_de_busy;
    assign src[4+`SISC_S2_UBUF_EF]     = i_ubuf_ef_busy;

    // subcode flag only announces; the host must drain in time
    assign src[4+`SISC_S2_SUBCODE]     = i_subcode_ready;
    assign src[4+`SISC_S2_UFIFO_OVW]   = i_ufifo_overwrite;

    // per-flag control gathered from the byte registers
    assign f_mask = {mask2[5:0], mask1[3:0]};
    assign f_msb  = {mode2_msb[5:0], mode1_msb[3:0]};
    assign f_lsb  = {mode2_lsb[5:0], mode1_lsb[3:0]};
    assign f_clr  = {{6{clr2}}, {4{clr1}}};

    // ----------
    // one sticky cell per flag
    // ----------
    genvar gi;
    generate
        for (gi = 0; gi < `SISC_NFLAG; gi = gi + 1) begin : g_flag
            sisc_flag_cell u_cell (
                .i_clk    (i_clk),
                .i_rst_b  (i_rst_b),
                .i_src    (src[gi]),
                .i_mode   ({f_msb[gi], f_lsb[gi]}),
                .i_mask   (f_mask[gi]),
                .i_rd_clr (f_clr[gi]),
                .o_flag   (flag[gi])
            );
        end
    endgenerate

    // status views; unimplemented and reserved bits read zero
    assign stat1 = {4'h0, flag[3:0]};
    assign stat2 = {2'h0, flag[9:4]};

    // ----------
    // interrupt pin, registered so the port comes from a flop
    // ----------
    // pin level follows the masked flags only
    // flags are already masked, so any set flag raises the pin;
    // this costs one cycle of latency after a flag sets
    always @(posedge i_clk or negedge i_rst_b) begin
        if (!i_rst_b)
            o_int <= 1'b0;
        else
            o_int <= |flag;
    end

    // -----------------------------------------------------------------
    // write channel handshakes
    // -----------------------------------------------------------------
    assign aw_take      = i_awvalid & o_awready;
    assign w_take       = i_wvalid & o_wready;
    assign wr_do        = aw_full & w_full & ~o_bvalid;
    assign next_aw_full = (aw_full | aw_take) & ~wr_do;
    assign next_w_full  = (w_full | w_take) & ~wr_do;
    assign next_bvalid  = wr_do | (o_bvalid & ~i_bready);

    // address and data latch independently, in either order
    always @(posedge i_clk or negedge i_rst_b) begin
        if (!i_rst_b) begin
            aw_full   <= 1'b0;
            w_full    <= 1'b0;
            o_awready <= 1'b0;
            o_wready  <= 1'b0;
            o_bvalid  <= 1'b0;
            o_bresp   <= `SISC_RESP_OKAY;
            wr_idx    <= 6'h00;
            wr_byte   <= 8'h00;
            wr_en0    <= 1'b0;
        end else begin
            aw_full   <= next_aw_full;
            w_full    <= next_w_full;
            // ready stays low while a response is pending
            o_awready <= ~next_aw_full & ~next_bvalid;
            o_wready  <= ~next_w_full & ~next_bvalid;
            o_bvalid  <= next_bvalid;
            if (aw_take)
                wr_idx <= i_awaddr[7:2];
            if (w_take) begin
                wr_byte <= i_wdata[7:0];
                wr_en0  <= i_wstrb[0];
            end
            if (wr_do)
                o_bresp <= wr_hit ? `SISC_RESP_OKAY : `SISC_RESP_SLVERR;
        end
    end

    // unknown indices answer with an error
    // mapped write targets; status registers accept and ignore writes
    always @* begin
        case (wr_idx)
            `SISC_IDX_STAT1,
            `SISC_IDX_STAT2,
            `SISC_IDX_MASK1,
            `SISC_IDX_MODE1_MSB,
            `SISC_IDX_MODE1_LSB,
            `SISC_IDX_MASK2,
            `SISC_IDX_MODE2_MSB,
            `SISC_IDX_MODE2_LSB,
            `SISC_IDX_RXERR:    wr_hit = 1'b1;
            default:            wr_hit = 1'b0;
        endcase
    end

    // -----------------------------------------------------------------
    // control register update
    // -----------------------------------------------------------------
    always @(posedge i_clk or negedge i_rst_b) begin
        if (!i_rst_b) begin
            mask1     <= `SISC_REG_RESET;
            mode1_msb <= `SISC_REG_RESET;
            mode1_lsb <= `SISC_REG_RESET;
            mask2     <= `SISC_REG_RESET;
            mode2_msb <= `SISC_REG_RESET;
            mode2_lsb <= `SISC_REG_RESET;
        // only byte lane 0 carries register data
        end else if (wr_do && wr_en0) begin
            case (wr_idx)
                `SISC_IDX_MASK1:     mask1     <= wr_byte;
                `SISC_IDX_MODE1_MSB: mode1_msb <= wr_byte;
                `SISC_IDX_MODE1_LSB: mode1_lsb <= wr_byte;
                // top two bits of the second set are fixed at zero
                `SISC_IDX_MASK2:     mask2     <= {2'h0, wr_byte[5:0]};
                `SISC_IDX_MODE2_MSB: mode2_msb <= {2'h0, wr_byte[5:0]};
                `SISC_IDX_MODE2_LSB: mode2_lsb <= {2'h0, wr_byte[5:0]};
                default:             mask1     <= mask1;
            endcase
        end
    end

    // ----------
    // read channel
    // ----------
    assign ar_take     = i_arvalid & o_arready;
    assign next_rvalid = ar_take | (o_rvalid & ~i_rready);
    assign rd_idx      = i_araddr[7:2];

    // a taken read of a status word clears it at the same edge,
    // while the old contents are latched into the read data
    assign clr1 = ar_take & (rd_idx == `SISC_IDX_STAT1);
    assign clr2 = ar_take & (rd_idx == `SISC_IDX_STAT2);

    // flags are already masked, so
    // software never masks them again
    // read mux
    always @* begin
        rd_hit = 1'b1;
        case (rd_idx)
            `SISC_IDX_STAT1:     rd_val = stat1;
            `SISC_IDX_STAT2:     rd_val = stat2;
            `SISC_IDX_MASK1:     rd_val = mask1;
            `SISC_IDX_MODE1_MSB: rd_val = mode1_msb;
            `SISC_IDX_MODE1_LSB: rd_val = mode1_lsb;
            `SISC_IDX_MASK2:     rd_val = mask2;
            `SISC_IDX_MODE2_MSB: rd_val = mode2_msb;
            `SISC_IDX_MODE2_LSB: rd_val = mode2_lsb;
            `SISC_IDX_RXERR:     rd_val = i_rx_err_cause;
            default: begin
                rd_val = 8'h00;  // unmapped reads zero with an error
                rd_hit = 1'b0;
            end
        endcase
    end

    // arready low while an answer waits
    // read response register
    always @(posedge i_clk or negedge i_rst_b) begin
        if (!i_rst_b) begin
            o_arready <= 1'b0;
            o_rvalid  <= 1'b0;
            o_rdata   <= 32'h00000000;
            o_rresp   <= `SISC_RESP_OKAY;
        end else begin
            o_rvalid  <= next_rvalid;
            o_arready <= ~next_rvalid;
            if (ar_take) begin
                o_rdata <= {24'h000000, rd_val};
                o_rresp <= rd_hit ? `SISC_RESP_OKAY : `SISC_RESP_SLVERR;
            end
        end
    end

endmodule // sisc_top

// ==== verif/sisc_top_props.sv ====
// port checker for the status capture block, bound into its top
`include "sisc_defines.vh"
module sisc_top_props (
    // clock and reset
    input wire                     i_clk,
    input wire                     i_rst_b,
    // register bus
    input wire                     i_awvalid,
    input wire                     o_awready,
    input wire [7:0]               i_awaddr,
    input wire                     i_wvalid,
    input wire                     o_wready,
    input wire                     o_bvalid,
    input wire                     i_arvalid,
    input wire                     o_arready,
    input wire [7:0]               i_araddr,
    input wire                     o_rvalid,
    input wire                     i_rready,
    input wire [31:0]              o_rdata,
    input wire [1:0]               o_rresp,
    // converter and pin
    input wire [`SISC_ACC_W-1:0]   i_right_acc,
    input wire                     i_right_vld,
    input wire [`SISC_SAMPLE_W-1:0] o_right_sample,
    input wire                     o_int
);
    logic [7:0]  rd_addr;   // address of the read in flight
    logic        mask_seen; // a mask register was addressed
    // ----
    // helper state
    // ----
    always @(posedge i_clk or negedge i_rst_b) begin
        if (!i_rst_b) begin
            rd_addr   <= 8'h00;
            mask_seen <= 1'b0;
        end else begin
            if (i_arvalid && o_arready)
                rd_addr <= i_araddr;
            // mask value is judged by the bench
            if (i_awvalid && o_awready && (i_awaddr == 8'h24 || i_awaddr == 8'h30))
                mask_seen <= 1'b1;
        end
    end
    // ----
    // properties
    // ----
    default clocking @(posedge i_clk); endclocking
    default disable iff (!i_rst_b);
    sequence s_rd_taken; i_arvalid && o_arready; endsequence
    sequence s_rd_wait; o_rvalid && !i_rready; endsequence
    sequence s_wr_taken; i_awvalid && o_awready && i_wvalid && o_wready; endsequence
    reset_quiet_a: assert property ($rose(i_rst_b) |-> !o_int && !o_rvalid && !o_bvalid)
        else $error("outputs not idle after reset");
    rd_answer_a: assert property (s_rd_taken |=> o_rvalid && !o_arready)
        else $error("read not answered next cycle");
    rd_hold_a: assert property (s_rd_wait |=> o_rvalid && $stable(o_rdata))
        else $error("read data dropped before taken");
    wr_answer_a: assert property (s_wr_taken |=> !o_awready && !o_wready ##1 o_bvalid)
        else $error("write not answered in two cycles");
    stat2_top_zero_a: assert property (o_rvalid && rd_addr == 8'h20 |-> o_rdata[31:6] == 26'h0)
        else $error("second status top bits not zero");
    unmapped_read_a: assert property (o_rvalid && rd_addr < 8'h1C |-> o_rdata == 32'h0
        && o_rresp == `SISC_RESP_SLVERR) else $error("unmapped read not refused");
    sat_high_a: assert property (i_right_vld && !i_right_acc[25] && i_right_acc[24:23] != 2'h0
        |=> o_right_sample == 24'h7FFFFF) else $error("positive overrange not clipped");
    sat_low_a: assert property (i_right_vld && i_right_acc[25] && i_right_acc[24:23] != 2'h3
        |=> o_right_sample == 24'h800000) else $error("negative overrange not clipped");
    sat_pass_a: assert property (i_right_vld && i_right_acc[25:23] inside {3'h0, 3'h7}
        |=> o_right_sample == $past(i_right_acc[23:0])) else $error("in-range sample altered");
    int_needs_mask_a: assert property (o_int |-> mask_seen)
        else $error("interrupt with all masks at reset value");
endmodule // sisc_top_props

bind sisc_top sisc_top_props u_props (.*);

// ==== verif/test_sisc_top.sv ====
// self-checking bench for the status capture block
`include "sisc_defines.vh"
module test_sisc_top;
    timeunit 1ns;
    timeprecision 1ps;
    localparam logic [7:0] A_S1 = {`SISC_IDX_STAT1, 2'h0}, A_S2 = {`SISC_IDX_STAT2, 2'h0},
        A_K1 = {`SISC_IDX_MASK1, 2'h0}, A_H1 = {`SISC_IDX_MODE1_MSB, 2'h0},
        A_L1 = {`SISC_IDX_MODE1_LSB, 2'h0}, A_K2 = {`SISC_IDX_MASK2, 2'h0},
        A_H2 = {`SISC_IDX_MODE2_MSB, 2'h0}, A_L2 = {`SISC_IDX_MODE2_LSB, 2'h0},
        A_RX = {`SISC_IDX_RXERR, 2'h0};
    localparam logic [7:0] ADDRS [11] = '{A_S1, A_S2, A_K1, A_H1, A_L1, A_K2, A_H2, A_L2, A_RX,
        8'h00, 8'h40};
    logic        i_clk, i_rst_b, i_awvalid, i_wvalid, i_bready, i_arvalid, i_rready, i_right_vld;
    logic        i_cbuf_de_busy, i_cbuf_ef_busy, i_rx_err, i_conv_overflow, i_conv_tracking;
    logic        i_ubuf_de_busy, i_ubuf_ef_busy, i_subcode_ready, i_ufifo_overwrite;
    logic [7:0]  i_awaddr, i_araddr, i_rx_err_cause;
    logic [31:0] i_wdata;
    logic [3:0]  i_wstrb;
    logic [25:0] i_right_acc;
    wire         o_awready, o_wready, o_bvalid, o_arready, o_rvalid, o_int;
    wire  [1:0]  o_bresp, o_rresp;
    wire  [31:0] o_rdata;
    wire  [23:0] o_right_sample;
    int          n_errors = 0, n_compared = 0;
    logic [31:0] seed = 32'h2A9E;  // random stream state
    logic        run_rand = 1'b0;  // sources toggle while set
    logic [7:0]  f1, f2, p1, p2, s1, s2, m1, h1, l1, m2, h2, l2, pa, pd; // model registers
    logic        mint, pend, rhs;  // model pin, pending write, read taken
    logic [23:0] msmp;             // model clipped sample
    logic [31:0] exp_q[$];         // expected read data in order
    sisc_top dut (.*);
    always #12.5 i_clk = ~i_clk;
    // ----
    // helpers
    // ----
    function automatic logic [31:0] lfsr(input logic [31:0] s);
        return {s[30:0], s[31] ^ s[21] ^ s[1] ^ s[0]};
    endfunction
    // masked flag clears, trigger sets, read clears; code 11 never fires
    function automatic logic [7:0] nxt(input logic [7:0] f, s, p, k, h, l, input logic c);
        return k & ((~h & ~l & s & ~p) | (~h & l & ~s & p) | (h & ~l & s) | ({8{~c}} & f));
    endfunction
    function automatic logic mapped(input logic [7:0] a);
        return a inside {A_S1, A_S2, A_K1, A_H1, A_L1, A_K2, A_H2, A_L2, A_RX};
    endfunction
    function automatic logic [7:0] regval(input logic [7:0] a);
        case (a)
            A_S1: return f1;
            A_S2: return f2;
            A_K1: return m1;
            A_H1: return h1;
            A_L1: return l1;
            A_K2: return m2;
            A_H2: return h2;
            A_L2: return l2;
            A_RX: return i_rx_err_cause;
            default: return 8'h00;
        endcase
    endfunction
    task automatic cmp_word(input string what, input logic [31:0] exp, got);
        n_compared++;
        if (got !== exp) begin
            n_errors++;
            $display("ERROR %s expected %h seen %h", what, exp, got);
        end
    endtask
    task automatic cmp_flag(input string what, input logic exp, got);
        n_compared++;
        if (got !== exp) begin
            n_errors++;
            $display("ERROR %s expected %b seen %b", what, exp, got);
        end
    endtask
    // write: address and data offered together, each released when taken
    task automatic wr(input logic [7:0] a, d, input logic [3:0] s = 4'h1);
        @(posedge i_clk);
        {i_awvalid, i_wvalid, i_bready} <= 3'h7;
        i_awaddr <= a;
        i_wdata  <= {24'h0, d};
        i_wstrb  <= s;
        do begin
            @(posedge i_clk);
            if (o_awready === 1'b1) i_awvalid <= 1'b0;
            if (o_wready === 1'b1) i_wvalid <= 1'b0;
        end while (i_awvalid || i_wvalid);
        while (o_bvalid !== 1'b1) @(posedge i_clk);
        i_bready <= 1'b0;
        cmp_word("bresp", mapped(a) ? `SISC_RESP_OKAY : `SISC_RESP_SLVERR, o_bresp);
    endtask
    // read: slow holds off rready so the answer has to stand
    task automatic rd(input logic [7:0] a, input bit slow = 1'b0);
        @(posedge i_clk);
        i_arvalid <= 1'b1;
        i_araddr  <= a;
        i_rready  <= !slow;
        do @(posedge i_clk); while (o_arready !== 1'b1);
        i_arvalid <= 1'b0;
        if (slow) begin
            repeat (2) @(posedge i_clk);
            i_rready <= 1'b1;
        end
        do @(posedge i_clk); while (o_rvalid !== 1'b1);
        i_rready <= 1'b0;
        cmp_word("rdata", exp_q.pop_front(), o_rdata);
        cmp_word("rresp", mapped(a) ? `SISC_RESP_OKAY : `SISC_RESP_SLVERR, o_rresp);
    endtask
    task automatic test_end(input string name);
        $display("test %s done, mismatches so far %0d", name, n_errors);
    endtask
    task automatic complete_run();
        $display("compared %0d, mismatches %0d", n_compared, n_errors);
        if (n_errors == 0 && n_compared > 0)
            $display("Test passed");
        else
            $display("Test failed");
        $finish;
    endtask
    // ----
    // random sources and reference model
    // ----
    always @(posedge i_clk) begin
        if (run_rand) begin
            seed = lfsr(seed);
            {i_cbuf_de_busy, i_cbuf_ef_busy, i_rx_err, i_conv_overflow, i_conv_tracking,
                i_ubuf_de_busy, i_ubuf_ef_busy, i_subcode_ready, i_ufifo_overwrite} <= seed[8:0];
            i_right_vld    <= seed[9];
            i_right_acc    <= seed[31:6];
            i_rx_err_cause <= seed[7:0];
        end
    end
    always @(posedge i_clk) begin
        if (!i_rst_b) begin
            {f1, f2, p1, p2, m1, h1, l1, m2, h2, l2, mint, pend, msmp} = '0;
        end else begin
            cmp_flag("o_int", mint, o_int);
            cmp_word("o_right_sample", {8'h0, msmp}, {8'h0, o_right_sample});
            s1 = {4'h0, i_right_vld && !(i_right_acc[25:23] inside {3'h0, 3'h7}),
                i_cbuf_de_busy, i_cbuf_ef_busy, i_rx_err};
            s2 = {2'h0, i_conv_overflow, i_conv_tracking, i_ubuf_de_busy, i_ubuf_ef_busy,
                i_subcode_ready, i_ufifo_overwrite};
            rhs = i_arvalid && o_arready;
            if (rhs) exp_q.push_back({24'h0, regval(i_araddr)});
            mint = |{f1, f2};
            f1 = nxt(f1, s1, p1, m1, h1, l1, rhs && i_araddr == A_S1);
            f2 = nxt(f2, s2, p2, m2, h2, l2, rhs && i_araddr == A_S2);
            p1 = s1;
            p2 = s2;
            if (i_right_vld) msmp = (i_right_acc[25:23] inside {3'h0, 3'h7}) ?
                i_right_acc[23:0] : (i_right_acc[25] ? 24'h800000 : 24'h7FFFFF);
            // a write lands one edge after it is taken
            if (pend) begin
                case (pa)
                    A_K1: m1 = pd;
                    A_H1: h1 = pd;
                    A_L1: l1 = pd;
                    A_K2: m2 = pd & 8'h3F;
                    A_H2: h2 = pd & 8'h3F;
                    A_L2: l2 = pd & 8'h3F;
                    default: ;
                endcase
            end
            pend = i_awvalid && o_awready && i_wvalid && o_wready && i_wstrb[0];
            pa = i_awaddr;
            pd = i_wdata[7:0];
        end
    end
    // ----
    // tests
    // ----
    initial begin
        {i_clk, i_rst_b, i_awvalid, i_wvalid, i_bready, i_arvalid, i_rready, i_right_vld,
            i_cbuf_de_busy, i_cbuf_ef_busy, i_rx_err, i_conv_overflow, i_conv_tracking,
            i_ubuf_de_busy, i_ubuf_ef_busy, i_subcode_ready, i_ufifo_overwrite, i_awaddr,
            i_araddr, i_rx_err_cause, i_wdata, i_wstrb, i_right_acc} = '0;
        repeat (3) @(posedge i_clk);
        i_rst_b <= 1'b1;
        foreach (ADDRS[i]) rd(ADDRS[i], 1'b1);
        test_end("reset values");
        foreach (ADDRS[i]) begin
            seed = lfsr(seed);
            wr(ADDRS[i], seed[7:0]);
            rd(ADDRS[i]);
        end
        wr(A_K1, 8'h5A, 4'hE);
        rd(A_K1);
        test_end("register access");
        // codes walk down so the last one leaves flags set for masking
        for (int c = 3; c >= 0; c--) begin
            wr(A_K1, 8'hFF);
            wr(A_K2, 8'hFF);
            wr(A_H1, {8{c[1]}});
            wr(A_L1, {8{c[0]}});
            wr(A_H2, {8{c[1]}});
            wr(A_L2, {8{c[0]}});
            run_rand <= 1'b1;
            repeat (10) begin
                repeat (seed[2:0]) @(posedge i_clk);
                rd(A_S1);
                rd(A_S2);
            end
            rd(A_RX);
            run_rand <= 1'b0;
            repeat (2) rd(A_S2);
            test_end("trigger mode");
        end
        wr(A_K1, 8'h00);
        wr(A_K2, 8'h00);
        run_rand <= 1'b1;
        repeat (6) begin
            rd(A_S1);
            rd(A_S2);
        end
        run_rand <= 1'b0;
        test_end("masked sources");
        complete_run();
    end
    // hang guard, ample margin
    initial begin
        repeat (20000) @(posedge i_clk);
        n_errors++;
        complete_run();
    end
endmodule // test_sisc_top
